// ==== src/spm_pkg.sv ====
// Package: register map, patterns, timing and states of the flash sequencer
package spm_pkg;
  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [11:0] CTL_ADDR = 12'h000;
  localparam logic [11:0] LOCK_ADDR = 12'h004;
  localparam logic [11:0] STAT_ADDR = 12'h008;
  // ***************************************************************
  // Control bit positions and accepted patterns
  // ***************************************************************
  localparam int CTL_EN = 0;
  localparam int CTL_ERS = 1;
  localparam int CTL_WRT = 2;
  localparam int CTL_RFL = 3;
  localparam int CTL_CLR = 4;
  localparam logic [4:0] CTL_RESET = 5'h00;
  localparam logic [4:0] PAT_FILL = 5'h01;
  localparam logic [4:0] PAT_ERASE = 5'h03;
  localparam logic [4:0] PAT_WRITE = 5'h05;
  localparam logic [4:0] PAT_RFL = 5'h09;
  localparam logic [4:0] PAT_CLR = 5'h11;
  // ***************************************************************
  // Fuse bit positions, lock and erased values
  // ***************************************************************
  localparam int FH_SELFPRG = 4;
  localparam int FH_DEBUG = 3;
  localparam logic [1:0] LOCK_ERASED = 2'h3;
  localparam logic [15:0] WORD_ERASED = 16'hFFFF;
  // ***************************************************************
  // Windows and operation timing
  // ***************************************************************
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] LPM_LAST = 3'h2;
  localparam int CLK_NS = 25;
  localparam int T_MIN_NS = 3700000;
  localparam int T_MAX_NS = 4500000;
  localparam int OP_MIN_CYC = (T_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int OP_MAX_CYC = T_MAX_NS / CLK_NS;
  // ***************************************************************
  // Flash operation states
  // ***************************************************************
  typedef enum logic [3:0] {
    OP_IDLE = 4'h1,
    OP_ERASE = 4'h2,
    OP_WRITE = 4'h4,
    OP_LOCK = 4'h8
  } op_state_t;
endpackage

// ==== src/self_program_flash_control.sv ====
// Self-programming flash sequencer with APB control and CPU strobes
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01: Erase, page write and lock write last a fixed time within 3.7-4.5 ms.
// RULE_02: Control register bits 7..5 always read as zero.
// RULE_03: Clear-buffer pattern empties the whole temporary page buffer.
// RULE_04: Armed fuse/lock read returns fuse or lock byte to LOAD_PROGRAM_INSTR within three cycles.
// RULE_05: Armed page write plus store writes buffer to the Z-selected page.
// RULE_06: Page-write bit clears on completion or after four unused cycles.
// RULE_07: Armed page erase plus store erases the Z-selected page.
// RULE_08: Page-erase bit clears on completion or after four unused cycles.
// RULE_09: CPU is halted for the whole erase or write.
// RULE_10: Enable bit opens the store instruction for four cycles only.
// RULE_11: Enable alone makes store put R1:R0 in buffer word at Z.
// RULE_12: Enable bit clears after a store or four unused cycles.
// RULE_13: Enable bit reads set while an erase or write runs.
// RULE_14: Only the listed five-bit patterns take effect; others are ignored.
// RULE_15: A running flash operation completes despite a system reset.
// RULE_16: Two lock bits, programmed to zero, restored to one only by chip erase; the code also restores them on power-on reset (por_n).
// RULE_17: Programmed debug fuse permits debug readout whatever the lock bits.
// RULE_18: Lock mode 1 applies no restrictions.
// RULE_19: Lock mode 2 blocks external programming, fuses and debug link.
// RULE_20: Lock mode 3 also blocks external verification reads.
// RULE_21: Store stays disabled unless the self-program fuse is programmed.
// RULE_22: EEPROM write blocks flash programming and fuse/lock reads.
// RULE_23: Erased page reads all ones; erase finishes before any write.
module self_program_flash_control
  import spm_pkg::*;
#(
  parameter int OP_CYCLES = OP_MIN_CYC,
  parameter int PAGE_WORDS = 16,
  parameter int PAGES = 32
) (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // System reset, active low
  input wire logic por_n, // Power-on reset of flash engine
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped
  input wire logic spm_exec, // CPU executes store instr
  input wire logic lpm_exec, // CPU executes load instr
  input wire logic [15:0] z_ptr, // Z pointer
  input wire logic [15:0] r1r0, // Store data word
  output logic [7:0] lpm_data, // Load result byte
  output logic lpm_valid, // Load result strobe
  output logic cpu_halt, // Stall CPU
  input wire logic [7:0] fuse_low, // Fuse low byte
  input wire logic [7:0] fuse_high, // Fuse high byte
  input wire logic eeprom_write_busy, // EEPROM write running
  input wire logic chip_erase, // Chip erase pulse
  output logic ext_prog_allow, // External programming allowed
  output logic ext_verify_allow, // External verify allowed
  output logic fuse_write_allow, // Fuse changes allowed
  output logic debug_link_enable, // Debug link usable
  output logic debug_readout_allow // Debug memory readout
);
  localparam int WB = $clog2(PAGE_WORDS);
  localparam int PB = $clog2(PAGES);
  localparam int FW = PAGE_WORDS * PAGES;
  localparam int TW = $clog2(OP_CYCLES + 1);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic pat_valid(input logic [4:0] p);
    return p == PAT_FILL || p == PAT_ERASE || p == PAT_WRITE ||
      p == PAT_RFL || p == PAT_CLR;
  endfunction

  function automatic logic [7:0] fuse_sel(input logic [1:0] z,
    input logic [1:0] lk, input logic [7:0] fl, input logic [7:0] fh);
    if (z[0] && !z[1])
      return {6'h3F, lk};
    else if (z[0])
      return fh;
    else
      return fl;
  endfunction

  // ***************************************************************
  // State
  // ***************************************************************
  logic [4:0] ctl_q, ctl_d;
  logic [2:0] arm_q, arm_d;
  op_state_t op_q, op_d;
  logic [TW-1:0] cnt_q;
  logic [PB-1:0] page_q;
  logic [1:0] lockval_q, lock_q;
  logic [15:0] buf_q [PAGE_WORDS];
  logic [15:0] mem_q [FW];
  logic [31:0] prdata_q;
  logic [7:0] lpm_data_q;
  logic lpm_valid_q;

  // ***************************************************************
  // APB decode
  // ***************************************************************
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctl = paddr == CTL_ADDR;
  wire hit_lock = paddr == LOCK_ADDR;
  wire hit_stat = paddr == STAT_ADDR;
  wire mapped = hit_ctl || hit_lock || hit_stat;
  wire busy = op_q != OP_IDLE;
  wire op_done = busy && cnt_q == '0;
  wire [PB-1:0] z_page = z_ptr[WB+PB:WB+1];
  wire [WB-1:0] z_word = z_ptr[WB:1];
  wire fuse_ok = !fuse_high[FH_SELFPRG]; // see RULE_21
  wire ctl_accept = apb_wr && hit_ctl && pat_valid(pwdata[4:0]) &&
    fuse_ok && !eeprom_write_busy && !busy; // see RULE_14 see RULE_22
  wire spm_hit = spm_exec && ctl_q[CTL_EN] && arm_q != 3'h0 &&
    !busy && !eeprom_write_busy; // see RULE_10 see RULE_22
  wire lpm_rfl = lpm_exec && ctl_q == PAT_RFL && arm_q >= LPM_LAST &&
    !busy && !eeprom_write_busy; // see RULE_04 see RULE_22
  wire start_erase = spm_hit && ctl_q == PAT_ERASE; // see RULE_07
  wire start_write = spm_hit && ctl_q == PAT_WRITE; // see RULE_05
  wire start_lock = spm_hit && ctl_q == PAT_RFL;
  wire fill_word = spm_hit && ctl_q == PAT_FILL; // see RULE_11
  wire buf_clear = (ctl_accept && pwdata[4:0] == PAT_CLR) ||
    (op_done && op_q == OP_WRITE); // see RULE_03
  wire [4:0] op_bits = {2'b00, op_q == OP_WRITE, op_q == OP_ERASE, 1'b1};
  wire [4:0] ctl_rd = busy ? op_bits : ctl_q; // see RULE_13
  wire [31:0] stat_rd = {28'h0, lock_q, arm_q != 3'h0, busy};
  wire [31:0] rd_mux = hit_ctl ? {27'h0, ctl_rd} : // see RULE_02
    hit_lock ? {30'h0, lock_q} : hit_stat ? stat_rd : 32'h0;

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign lpm_data = lpm_data_q;
  assign lpm_valid = lpm_valid_q;
  assign cpu_halt = busy; // see RULE_09

  // ***************************************************************
  // Lock protection decode
  // ***************************************************************
  assign ext_prog_allow = &lock_q; // see RULE_18 see RULE_19
  assign ext_verify_allow = lock_q[1]; // see RULE_20
  assign fuse_write_allow = &lock_q; // see RULE_19
  assign debug_link_enable = &lock_q && !fuse_high[FH_DEBUG];
  assign debug_readout_allow = !fuse_high[FH_DEBUG]; // see RULE_17

  // ***************************************************************
  // Control register and arming window
  // ***************************************************************
  always_comb
  begin
    ctl_d = ctl_q;
    arm_d = arm_q;
    if (ctl_accept)
    begin
      ctl_d = pwdata[4:0];
      arm_d = ARM_CYCLES;
    end
    else if (spm_hit || lpm_rfl || arm_q == 3'h1)
    begin
      ctl_d = CTL_RESET; // see RULE_06 see RULE_08 see RULE_12
      arm_d = 3'h0;
    end
    else if (arm_q != 3'h0)
      arm_d = arm_q - 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_q <= CTL_RESET;
      arm_q <= 3'h0;
    end
    else
    begin
      ctl_q <= ctl_d;
      arm_q <= arm_d;
    end
  end

  // ***************************************************************
  // APB read data and load results
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0;
      lpm_data_q <= 8'h00;
      lpm_valid_q <= 1'b0;
    end
    else
    begin
      if (apb_setup && !pwrite)
        prdata_q <= rd_mux;
      lpm_valid_q <= lpm_exec && !busy;
      if (lpm_rfl)
        lpm_data_q <= fuse_sel(z_ptr[1:0], lock_q, fuse_low, fuse_high);
      else if (lpm_exec && !busy)
        lpm_data_q <= z_ptr[0] ? mem_q[z_ptr[WB+PB:1]][15:8] :
          mem_q[z_ptr[WB+PB:1]][7:0];
    end
  end

  // ***************************************************************
  // Flash engine, kept running through system reset
  // ***************************************************************
  always_comb
  begin
    op_d = op_q;
    if (op_done)
      op_d = OP_IDLE;
    else if (start_erase)
      op_d = OP_ERASE;
    else if (start_write)
      op_d = OP_WRITE;
    else if (start_lock)
      op_d = OP_LOCK;
  end

  always_ff @(posedge pclk or negedge por_n) // see RULE_15
  begin
    if (!por_n)
    begin
      op_q <= OP_IDLE;
      cnt_q <= '0;
      page_q <= '0;
      lockval_q <= LOCK_ERASED;
    end
    else
    begin
      op_q <= op_d;
      if (!busy && op_d != OP_IDLE)
      begin
        cnt_q <= TW'(OP_CYCLES - 1); // see RULE_01
        page_q <= z_page;
        lockval_q <= r1r0[1:0];
      end
      else if (busy)
        cnt_q <= cnt_q - TW'(1);
    end
  end

  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      lock_q <= LOCK_ERASED;
    else if (chip_erase)
      lock_q <= LOCK_ERASED; // see RULE_16
    else if (op_done && op_q == OP_LOCK)
      lock_q <= lock_q & lockval_q;
  end

  // ***************************************************************
  // Temporary page buffer
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
        buf_q[i] <= WORD_ERASED;
    end
    else if (buf_clear)
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
        buf_q[i] <= WORD_ERASED;
    end
    else if (fill_word)
      buf_q[z_word] <= buf_q[z_word] & r1r0;
  end

  // ***************************************************************
  // Flash array
  // ***************************************************************
  always_ff @(posedge pclk)
  begin
    if (chip_erase)
    begin
      for (int i = 0; i < FW; i++)
        mem_q[i] <= WORD_ERASED;
    end
    else if (op_done && op_q == OP_ERASE)
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
        mem_q[{page_q, WB'(i)}] <= WORD_ERASED; // see RULE_23
    end
    else if (op_done && op_q == OP_WRITE)
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
        mem_q[{page_q, WB'(i)}] <= mem_q[{page_q, WB'(i)}] & buf_q[i];
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  logic [TW:0] dur_q;
  op_state_t last_op_q;
  logic [PB-1:0] last_page_q;

  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      dur_q <= '0;
      last_op_q <= OP_IDLE;
      last_page_q <= '0;
    end
    else
    begin
      dur_q <= busy ? dur_q + (TW+1)'(1) : '0;
      if (op_done)
      begin
        last_op_q <= op_q;
        last_page_q <= page_q;
      end
    end
  end

  sequence s_write_armed;
    ctl_q == PAT_WRITE && arm_q != 3'h0 && !busy && !eeprom_write_busy;
  endsequence

  sequence s_erase_armed;
    ctl_q == PAT_ERASE && arm_q != 3'h0 && !busy && !eeprom_write_busy;
  endsequence

  a_op_duration: assert property ( // see RULE_01
    @(posedge pclk) disable iff (!por_n) op_done |-> dur_q ==
    (TW+1)'(OP_CYCLES - 1)) else $error("flash operation length wrong");

  a_reserved_zero: assert property ( // see RULE_02
    @(posedge pclk) disable iff (!presetn) apb_setup && !pwrite && hit_ctl
    |=> prdata[31:5] == 27'h0) else $error("reserved control bits not zero");

  a_clear_buffer: assert property ( // see RULE_03
    @(posedge pclk) disable iff (!presetn)
    ctl_accept && pwdata[4:0] == PAT_CLR |=> buf_q[0] == WORD_ERASED &&
    buf_q[PAGE_WORDS-1] == WORD_ERASED) else $error("page buffer not cleared");

  a_fuse_read: assert property ( // see RULE_04
    @(posedge pclk) disable iff (!presetn) lpm_rfl |=> lpm_valid &&
    lpm_data == fuse_sel($past(z_ptr[1:0]), lock_q, fuse_low, fuse_high))
    else $error("fuse or lock read wrong");

  a_write_start: assert property ( // see RULE_05 see RULE_13
    @(posedge pclk) disable iff (!presetn || !por_n)
    s_write_armed ##0 spm_exec |=> op_q == OP_WRITE && cpu_halt &&
    ctl_rd[CTL_WRT] && ctl_rd[CTL_EN])
    else $error("page write did not start");

  a_erase_start: assert property ( // see RULE_07 see RULE_09
    @(posedge pclk) disable iff (!presetn || !por_n)
    s_erase_armed ##0 spm_exec |=> op_q == OP_ERASE && cpu_halt &&
    page_q == $past(z_page))
    else $error("page erase did not start");

  a_arm_expires: assert property ( // see RULE_06 see RULE_08 see RULE_12
    @(posedge pclk) disable iff (!presetn || !por_n)
    ctl_accept ##1 (!spm_exec && !lpm_exec && !apb_wr) [*4]
    |=> ctl_q == CTL_RESET)
    else $error("armed bits outlived window");

  a_bad_pattern: assert property ( // see RULE_14
    @(posedge pclk) disable iff (!presetn) apb_wr && hit_ctl &&
    !pat_valid(pwdata[4:0]) && arm_q == 3'h0 |=> ctl_q == CTL_RESET)
    else $error("illegal pattern took effect");

  a_fuse_gate: assert property ( // see RULE_21
    @(posedge pclk) disable iff (!presetn) apb_wr && hit_ctl &&
    fuse_high[FH_SELFPRG] && arm_q == 3'h0 |=> ctl_q == CTL_RESET)
    else $error("armed without self-program fuse");

  a_eeprom_block: assert property ( // see RULE_22
    @(posedge pclk) disable iff (!presetn)
    eeprom_write_busy && ctl_q == CTL_RESET |=> ctl_q == CTL_RESET)
    else $error("armed during eeprom write");

  a_lock_modes: assert property ( // see RULE_18 see RULE_19 see RULE_20
    @(posedge pclk) disable iff (!por_n)
    (lock_q == 2'h2 |-> !ext_prog_allow && ext_verify_allow &&
    !fuse_write_allow && !debug_link_enable) and
    (lock_q == 2'h0 |-> !ext_prog_allow && !ext_verify_allow) and
    (lock_q == 2'h3 |-> ext_prog_allow && ext_verify_allow))
    else $error("lock mode decode wrong");

  a_erase_ones: assert property ( // see RULE_23
    @(posedge pclk) disable iff (!por_n) $fell(busy) &&
    last_op_q == OP_ERASE && !$past(chip_erase) |->
    mem_q[{last_page_q, WB'(0)}] == WORD_ERASED)
    else $error("erased page not all ones");

endmodule // self_program_flash_control
`default_nettype wire

// ==== testbench/cpu_model.sv ====
// CPU core model issuing store and load program instructions
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input wire logic pclk, // Clock
  input wire logic cpu_halt, // Stall from sequencer
  input wire logic [7:0] lpm_data, // Load result byte
  input wire logic lpm_valid, // Load result strobe
  output logic spm_exec, // Store instruction strobe
  output logic lpm_exec, // Load instruction strobe
  output logic [15:0] z_ptr, // Z pointer
  output logic [15:0] r1r0 // Store data word
);
  initial
  begin
    spm_exec = 1'b0;
    lpm_exec = 1'b0;
    z_ptr = 16'h0000;
    r1r0 = 16'h0000;
  end
  // One instruction after w+1 clock edges, never while halted
  task automatic issue(input int w, input logic st, input logic [15:0] z,
    input logic [15:0] d);
    repeat (w) @(posedge pclk);
    @(posedge pclk);
    while (cpu_halt !== 1'b0) @(posedge pclk);
    spm_exec <= st;
    lpm_exec <= !st;
    z_ptr <= z;
    r1r0 <= d;
    @(posedge pclk);
    spm_exec <= 1'b0;
    lpm_exec <= 1'b0;
    // Released lines show the inverse, not the old value
    z_ptr <= ~z;
    r1r0 <= ~d;
  endtask
  task automatic store(input int w, input logic [15:0] z,
    input logic [15:0] d);
    issue(w, 1'b1, z, d);
  endtask
  task automatic load(input logic [15:0] z, output logic [7:0] q,
    output logic ok);
    issue(0, 1'b0, z, 16'h0000);
    @(posedge pclk);
    q = lpm_data;
    ok = lpm_valid;
  endtask
endmodule // cpu_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the self-programming flash sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
      fail_count++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top;
  import spm_pkg::*;
  localparam int OPC = 20;
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, e, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic spm_exec, lpm_exec, lpm_valid, cpu_halt, eeprom_write_busy;
  logic [15:0] z_ptr, r1r0;
  logic [7:0] lpm_data, fuse_low, fuse_high, b;
  logic chip_erase, ext_prog_allow, ext_verify_allow, fuse_write_allow;
  logic debug_link_enable, debug_readout_allow;
  logic [4:0] mode_v;
  logic [4:0] bad_pat [5] = '{5'h07, 5'h02, 5'h1F, 5'h13, 5'h0D};
  int tests_run, fail_count, halt_cnt, cycles;
  assign mode_v = {ext_prog_allow, ext_verify_allow, fuse_write_allow,
    debug_link_enable, debug_readout_allow};
  self_program_flash_control #(.OP_CYCLES(OPC)) self_program_flash_control_i (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spm_exec(spm_exec), .lpm_exec(lpm_exec), .z_ptr(z_ptr), .r1r0(r1r0),
    .lpm_data(lpm_data), .lpm_valid(lpm_valid), .cpu_halt(cpu_halt),
    .fuse_low(fuse_low), .fuse_high(fuse_high), .chip_erase(chip_erase),
    .eeprom_write_busy(eeprom_write_busy), .ext_prog_allow(ext_prog_allow),
    .ext_verify_allow(ext_verify_allow), .fuse_write_allow(fuse_write_allow),
    .debug_link_enable(debug_link_enable),
    .debug_readout_allow(debug_readout_allow));
  cpu_model cpu_model_i (.pclk(pclk), .cpu_halt(cpu_halt),
    .lpm_data(lpm_data), .lpm_valid(lpm_valid), .spm_exec(spm_exec),
    .lpm_exec(lpm_exec), .z_ptr(z_ptr), .r1r0(r1r0));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ***************************************************************
  // Cycle counting, halt length and hang guard
  // ***************************************************************
  always @(posedge pclk)
  begin
    cycles++;
    if (cpu_halt === 1'b1)
      halt_cnt <= halt_cnt + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ***************************************************************
  // APB master and test helpers
  // ***************************************************************
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a,
    input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, q);
  endtask
  function automatic logic [15:0] zw(input int pg, input int w);
    return 16'(pg * 32 + w * 2);
  endfunction
  task automatic fchk(input string nm, input logic [15:0] z,
    input logic [7:0] ex);
    cpu_model_i.load(z, b, ok);
    `CHK(nm, {1'b1, ex}, {ok, b});
  endtask
  task automatic op(input logic [4:0] p, input logic [15:0] z,
    input logic [15:0] d, input logic rst);
    int n, h0;
    apb(1'b1, CTL_ADDR, {27'h0, p});
    h0 = halt_cnt;
    cpu_model_i.store(0, z, d);
    if (rst)
    begin
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
    end
    else
    begin
      rchk("busy ctl", CTL_ADDR, {29'h0, p[2:0]});
      apb(1'b0, STAT_ADDR, 32'h0);
      `CHK("busy flag", 1'b1, q[0]);
    end
    n = 0;
    @(posedge pclk);
    while (cpu_halt !== 1'b0 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("halt cycles", OPC, halt_cnt - h0);
  endtask
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    {psel, penable, pwrite, chip_erase, eeprom_write_busy} = 5'h00;
    {paddr, pwdata, tests_run, fail_count} = '0;
    presetn = 1'b0;
    por_n = 1'b0;
    fuse_low = 8'h6A;
    fuse_high = 8'hE7;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    chip_erase <= 1'b1;
    @(posedge pclk);
    chip_erase <= 1'b0;
    rchk("ctl reset", CTL_ADDR, 32'h0);
    rchk("lock reset", LOCK_ADDR, 32'h3);
    `CHK("mode one", 5'h1F, mode_v);
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {e, q});
    apb(1'b1, CTL_ADDR, 32'hFFFF_FFE1);
    rchk("reserved bits", CTL_ADDR, 32'h1);
    repeat (6) @(posedge pclk);
    rchk("enable expiry", CTL_ADDR, 32'h0);
    foreach (bad_pat[i])
    begin
      apb(1'b1, CTL_ADDR, {27'h0, bad_pat[i]});
      rchk("bad pattern", CTL_ADDR, 32'h0);
    end
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, CTL_ADDR, {27'h0, (i == 0) ? PAT_WRITE : PAT_ERASE});
      cpu_model_i.store(5, zw(1, 0), 16'h0000);
      @(posedge pclk);
      `CHK("late store", 1'b0, cpu_halt);
      rchk("armed expiry", CTL_ADDR, 32'h0);
    end
    apb(1'b1, CTL_ADDR, {27'h0, PAT_FILL});
    cpu_model_i.store(0, zw(3, 4) | 16'h0001, 16'h1234);
    apb(1'b1, CTL_ADDR, {27'h0, PAT_FILL});
    cpu_model_i.store(2, zw(3, 9), 16'hABCD);
    op(PAT_ERASE, zw(3, 0), 16'h0000, 1'b0);
    op(PAT_WRITE, zw(3, 0), 16'h0000, 1'b0);
    fchk("word4 low", zw(3, 4), 8'h34);
    fchk("word4 high", zw(3, 4) | 16'h0001, 8'h12);
    fchk("word9 low", zw(3, 9), 8'hCD);
    fchk("word0", zw(3, 0), 8'hFF);
    apb(1'b1, CTL_ADDR, {27'h0, PAT_FILL});
    cpu_model_i.store(0, zw(5, 2), 16'h0000);
    apb(1'b1, CTL_ADDR, {27'h0, PAT_CLR});
    op(PAT_WRITE, zw(5, 0), 16'h0000, 1'b0);
    fchk("cleared buffer", zw(5, 2), 8'hFF);
    apb(1'b1, CTL_ADDR, {27'h0, PAT_RFL});
    fchk("fuse low", 16'h0000, fuse_low);
    apb(1'b1, CTL_ADDR, {27'h0, PAT_RFL});
    fchk("lock read", 16'h0001, 8'hFF);
    apb(1'b1, CTL_ADDR, {27'h0, PAT_RFL});
    fchk("fuse high", 16'h0003, fuse_high);
    op(PAT_RFL, 16'h0000, 16'h0002, 1'b0);
    rchk("lock two", LOCK_ADDR, 32'h2);
    `CHK("mode two", 5'h09, mode_v);
    op(PAT_RFL, 16'h0000, 16'h0000, 1'b0);
    `CHK("mode three", 5'h01, mode_v);
    apb(1'b1, CTL_ADDR, {27'h0, PAT_RFL});
    fchk("lock zero", 16'h0001, 8'hFC);
    fuse_high <= 8'hEF;
    @(posedge pclk);
    chip_erase <= 1'b1;
    @(posedge pclk);
    chip_erase <= 1'b0;
    rchk("lock erased", LOCK_ADDR, 32'h3);
    `CHK("debug fuse off", 5'h1C, mode_v);
    fuse_high <= 8'hF7;
    apb(1'b1, CTL_ADDR, {27'h0, PAT_FILL});
    rchk("no self fuse", CTL_ADDR, 32'h0);
    fuse_high <= 8'hE7;
    eeprom_write_busy <= 1'b1;
    apb(1'b1, CTL_ADDR, {27'h0, PAT_FILL});
    rchk("eeprom busy", CTL_ADDR, 32'h0);
    eeprom_write_busy <= 1'b0;
    apb(1'b1, CTL_ADDR, {27'h0, PAT_FILL});
    cpu_model_i.store(0, zw(3, 4), 16'h5A5A);
    op(PAT_WRITE, zw(3, 0), 16'h0000, 1'b0);
    fchk("refill", zw(3, 4), 8'h5A);
    op(PAT_ERASE, zw(3, 0), 16'h0000, 1'b1);
    fchk("erase after reset", zw(3, 4), 8'hFF);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
